// >>> include/css_consts.svh
// Constants for the channel state and modify block
//
// Overview of operation
// - Four state bits: three timer_a, one timer_b
// - Hardware updates each state bit continuously
// - Compare: zero below, one at or above
// - Capture: one after selected edge since clear
// - Hall inputs latched only on compare ready
// - Latched hall bits equal the compared pattern
// - Pair 00 keep, 01 set, 10 clear, 11 toggle
// - Timer_b channel: clear bit 14, set bit 6
// - Timer_a sets bits 0-2, clears 8-10
// - One write applies all requests together
// - Modify bits 13:11 ignored, read zero
// - Timer_a clock fields locked while running
// - Timer_b clock fields locked while running
// - Output passive when state equals select
`ifndef CSS_CONSTS_SVH
`define CSS_CONSTS_SVH

`define CSS_ADDR_W        8
`define CSS_DATA_W        16
`define CSS_NUM_CH        4
`define CSS_NUM_EVT       5

// Register offsets
`define CSS_OFS_STATE     8'h00
`define CSS_OFS_MODIFY    8'h04
`define CSS_OFS_TIMER_CONTROL_0     8'h08
`define CSS_OFS_CHCFG     8'h0C
`define CSS_OFS_IRQ_STAT  8'h10
`define CSS_OFS_IRQ_MASK  8'h14

// Reset values
`define CSS_RST_16        16'h0000

// compare_state fields
`define CSS_ST_HALL_LSB   3
`define CSS_ST_CH3        6
`define CSS_ST_PS_CH3     14

// compare_state_modify fields
`define CSS_MOD_SET3      6
`define CSS_MOD_CLR_LSB   8
`define CSS_MOD_CLR3      14

// timer_control_0 fields
`define CSS_TC_A_CLK_LSB  0
`define CSS_TC_A_PRE      3
`define CSS_TC_A_RUN      4
`define CSS_TC_B_CLK_LSB  8
`define CSS_TC_B_PRE      11
`define CSS_TC_B_RUN      12

// Channel config fields: mode bits 3:0, edge select pairs 11:4
`define CSS_CFG_EDGE_LSB  4

// Interrupt status bit of the hall latch event
`define CSS_EVT_HALL      4

`endif

// >>> include/css_pkg.sv
// Types for the channel state and modify block
package css_pkg;

  typedef enum logic [1:0] {
    CSS_EDGE_RISE = 2'b00,
    CSS_EDGE_FALL = 2'b01,
    CSS_EDGE_BOTH = 2'b10,
    CSS_EDGE_NONE = 2'b11
  } css_edge_e;

  typedef struct packed {
    logic state;
    logic cap_prev;
    logic hw_rise;
  } css_cell_s;

  typedef struct packed {
    logic [3:0]  cap_s1;
    logic [3:0]  cap_s2;
    logic [2:0]  hall_s1;
    logic [2:0]  hall_s2;
    logic [2:0]  hall_q;
    logic        hall_evt;
    logic [2:0]  a_clk;
    logic        a_pre;
    logic [2:0]  b_clk;
    logic        b_pre;
    logic [3:0]  ps;
    logic [15:0] chcfg;
    logic [4:0]  irq_stat;
    logic [4:0]  irq_mask;
    logic [15:0] rdata;
  } css_top_s;

endpackage

// >>> core/css_chan_cell.sv
// One channel state bit with compare, capture and software modify
`timescale 1ns/1ns
`include "css_consts.svh"

module css_chan_cell (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Channel setup
  input  wire logic              cap_mode,
  input  css_pkg::css_edge_e     edge_sel,
  // Timer compare inputs
  input  wire logic [15:0]       count,
  input  wire logic [15:0]       cmp_val,
  // Synchronised capture level
  input  wire logic              cap_level,
  // Software modify requests
  input  wire logic              sw_set,
  input  wire logic              sw_clr,
  // State and hardware set event
  output logic                   state,
  output logic                   hw_rise
);

  css_pkg::css_cell_s q;
  css_pkg::css_cell_s n;
  logic               edge_hit;
  logic               hw_next;

  always_comb begin
    n = q;
    case (edge_sel)
      css_pkg::CSS_EDGE_RISE: edge_hit = cap_level & ~q.cap_prev;
      css_pkg::CSS_EDGE_FALL: edge_hit = ~cap_level & q.cap_prev;
      css_pkg::CSS_EDGE_BOTH: edge_hit = cap_level ^ q.cap_prev;
      default:                edge_hit = 1'b0;
    endcase
    if (cap_mode) begin
      hw_next = q.state | edge_hit;
    end else begin
      hw_next = (count >= cmp_val);
    end
    n.cap_prev = cap_level;
    n.hw_rise  = 1'b0;
    // Software first, hardware otherwise
    if (sw_set && sw_clr) begin
      n.state = ~q.state;
    end else if (sw_set) begin
      n.state = 1'b1;
    end else if (sw_clr) begin
      n.state = 1'b0;
    end else begin
      n.state   = hw_next;
      n.hw_rise = hw_next & ~q.state;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign state   = q.state;
  assign hw_rise = q.hw_rise;

endmodule

// >>> core/css_top.sv
// Channel state bits, hall latch, modify register and clock lock
`timescale 1ns/1ns
`include "css_consts.svh"

module css_top (
  // Clock and reset
  input  wire logic [0:0]  clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Timer counts and compare values
  input  wire logic [15:0] timer_a_count,
  input  wire logic [15:0] timer_b_count,
  input  wire logic [15:0] cmp_val_0,
  input  wire logic [15:0] cmp_val_1,
  input  wire logic [15:0] cmp_val_2,
  input  wire logic [15:0] cmp_val_3,
  // Timer run bits
  input  wire logic        timer_a_run,
  input  wire logic        timer_b_run,
  // Capture pins
  input  wire logic [3:0]  cap_in,
  // Hall pins and compare ready event
  input  wire logic        hall_in_0,
  input  wire logic        hall_in_1,
  input  wire logic        hall_in_2,
  input  wire logic        hall_cmp_ready,
  // Timer clock setup
  output logic      [2:0]  timer_a_clock_sel,
  output logic             timer_a_extra_prescale,
  output logic      [2:0]  timer_b_clock_sel,
  output logic             timer_b_extra_prescale,
  // Channel state and compare outputs
  output logic      [3:0]  chan_state,
  output logic      [3:0]  cmp_out_active,
  // Interrupt
  output logic             irq
);

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------

  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // ---------------------------------------------------------------
  // State and channel wiring
  // ---------------------------------------------------------------

  css_pkg::css_top_s q;
  css_pkg::css_top_s n;

  logic [3:0][15:0] cmp_vals;
  logic [3:0]       ch_state;
  logic [3:0]       ch_rise;
  logic [3:0]       sw_set;
  logic [3:0]       sw_clr;
  logic             wr_modify;
  logic [15:0]      state_word;
  logic [15:0]      timer_control_0_word;

  assign cmp_vals[0] = cmp_val_0;
  assign cmp_vals[1] = cmp_val_1;
  assign cmp_vals[2] = cmp_val_2;
  assign cmp_vals[3] = cmp_val_3;

  assign wr_modify = reg_wr && hit(reg_addr, `CSS_OFS_MODIFY);

  // ---------------------------------------------------------------
  // Channel cells
  // ---------------------------------------------------------------

  genvar gi;
  generate
    for (gi = 0; gi < `CSS_NUM_CH; gi = gi + 1) begin : g_ch
      localparam int SET_POS = (gi == 3) ? `CSS_MOD_SET3 : gi;
      // Only set and clear positions are tapped, 13:11 dropped
      localparam int CLR_POS =
        (gi == 3) ? `CSS_MOD_CLR3 : `CSS_MOD_CLR_LSB + gi;
      // Set and clear pairs of one write, all channels at once
      assign sw_set[gi] = wr_modify & reg_wdata[SET_POS];
      assign sw_clr[gi] = wr_modify & reg_wdata[CLR_POS];

      css_chan_cell u_cell (
        .clk       (clk),
        .rst       (rst),
        .cap_mode  (q.chcfg[gi]),
        .edge_sel  (css_pkg::css_edge_e'(
                      q.chcfg[`CSS_CFG_EDGE_LSB + 2*gi +: 2])),
        .count     ((gi == 3) ? timer_b_count : timer_a_count),
        .cmp_val   (cmp_vals[gi]),
        .cap_level (q.cap_s2[gi]),
        .sw_set    (sw_set[gi]),
        .sw_clr    (sw_clr[gi]),
        .state     (ch_state[gi]),
        .hw_rise   (ch_rise[gi])
      );

      // Passive level when state equals its select bit
      assign cmp_out_active[gi] =
        (ch_state[gi] != q.ps[gi]);
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read words
  // ---------------------------------------------------------------

  always_comb begin
    state_word = `CSS_RST_16;
    state_word[2:0] = ch_state[2:0];
    state_word[`CSS_ST_CH3] = ch_state[3];
    state_word[`CSS_ST_HALL_LSB +: 3] = q.hall_q;
    for (int i = 0; i < `CSS_NUM_CH; i++) begin
      state_word[8 + 2*i] = q.ps[i];
    end
  end

  always_comb begin
    timer_control_0_word = `CSS_RST_16;
    timer_control_0_word[`CSS_TC_A_CLK_LSB +: 3] = q.a_clk;
    timer_control_0_word[`CSS_TC_A_PRE] = q.a_pre;
    timer_control_0_word[`CSS_TC_A_RUN] = timer_a_run;
    timer_control_0_word[`CSS_TC_B_CLK_LSB +: 3] = q.b_clk;
    timer_control_0_word[`CSS_TC_B_PRE] = q.b_pre;
    timer_control_0_word[`CSS_TC_B_RUN] = timer_b_run;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------

  always_comb begin
    n = q;

    // Two-stage synchronisers for pins
    n.cap_s1  = cap_in;
    n.cap_s2  = q.cap_s1;
    n.hall_s1 = {hall_in_2, hall_in_1, hall_in_0};
    n.hall_s2 = q.hall_s1;

    // Hall pattern held except on compare ready
    n.hall_evt = hall_cmp_ready;
    if (hall_cmp_ready) begin
      n.hall_q = q.hall_s2;
    end

    // Register writes
    if (reg_wr) begin
      if (hit(reg_addr, `CSS_OFS_STATE)) begin
        for (int i = 0; i < `CSS_NUM_CH; i++) begin
          n.ps[i] = reg_wdata[8 + 2*i];
        end
      end
      if (hit(reg_addr, `CSS_OFS_TIMER_CONTROL_0)) begin
        if (!timer_a_run) begin
          n.a_clk = reg_wdata[`CSS_TC_A_CLK_LSB +: 3];
          n.a_pre = reg_wdata[`CSS_TC_A_PRE];
        end
        if (!timer_b_run) begin
          n.b_clk = reg_wdata[`CSS_TC_B_CLK_LSB +: 3];
          n.b_pre = reg_wdata[`CSS_TC_B_PRE];
        end
      end
      if (hit(reg_addr, `CSS_OFS_CHCFG)) begin
        n.chcfg = reg_wdata;
      end
      if (hit(reg_addr, `CSS_OFS_IRQ_MASK)) begin
        n.irq_mask = reg_wdata[4:0];
      end
    end

    // Sticky events, clear by writing one, set wins
    n.irq_stat = q.irq_stat;
    if (reg_wr && hit(reg_addr, `CSS_OFS_IRQ_STAT)) begin
      n.irq_stat = q.irq_stat & ~reg_wdata[4:0];
    end
    n.irq_stat = n.irq_stat | {q.hall_evt, ch_rise};

    // Read data valid only in the cycle after the strobe
    n.rdata = `CSS_RST_16;
    if (reg_rd) begin
      case (reg_addr)
        `CSS_OFS_STATE:    n.rdata = state_word;
        `CSS_OFS_MODIFY:   n.rdata = `CSS_RST_16;
        `CSS_OFS_TIMER_CONTROL_0:    n.rdata = timer_control_0_word;
        `CSS_OFS_CHCFG:    n.rdata = q.chcfg;
        `CSS_OFS_IRQ_STAT: n.rdata = {11'h000, q.irq_stat};
        `CSS_OFS_IRQ_MASK: n.rdata = {11'h000, q.irq_mask};
        default:           n.rdata = `CSS_RST_16;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------

  assign reg_rdata              = q.rdata;
  assign timer_a_clock_sel      = q.a_clk;
  assign timer_a_extra_prescale = q.a_pre;
  assign timer_b_clock_sel      = q.b_clk;
  assign timer_b_extra_prescale = q.b_pre;
  assign chan_state             = ch_state;
  assign irq                    = |(q.irq_stat & q.irq_mask);

endmodule

// >>> tb/css_top_chk.sv
// Port-level checks for the channel state and modify block
`timescale 1ns/1ns
module css_chk (
  // Clock and reset
  input wire logic [0:0]  clk,
  input wire logic        rst,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // Run bits and clock setup
  input wire logic        timer_a_run,
  input wire logic        timer_b_run,
  input wire logic [2:0]  timer_a_clock_sel,
  input wire logic        timer_a_extra_prescale,
  input wire logic [2:0]  timer_b_clock_sel,
  input wire logic        timer_b_extra_prescale,
  // State and interrupt
  input wire logic [3:0]  chan_state,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic mod_wr;
  logic tc_wr;
  assign mod_wr = reg_wr && reg_addr == 8'h04;
  assign tc_wr  = reg_wr && reg_addr == 8'h08;
  AST_MOD_RD:
    assert property (reg_rd && reg_addr == 8'h04 |=> reg_rdata == 16'h0000)
    else $error("modify register read not zero");
  AST_SET0:
    assert property (mod_wr && reg_wdata[0] && !reg_wdata[8]
      |=> chan_state[0])
    else $error("channel 0 not set by write");
  AST_CLR2:
    assert property (mod_wr && reg_wdata[10] && !reg_wdata[2]
      |=> !chan_state[2])
    else $error("channel 2 not cleared by write");
  AST_SET3:
    assert property (mod_wr && reg_wdata[6] && !reg_wdata[14]
      |=> chan_state[3])
    else $error("channel 3 not set by write");
  AST_CLR3:
    assert property (mod_wr && reg_wdata[14] && !reg_wdata[6]
      |=> !chan_state[3])
    else $error("channel 3 not cleared by write");
  AST_A_LOCK:
    assert property (timer_a_run
      |=> $stable(timer_a_clock_sel) && $stable(timer_a_extra_prescale))
    else $error("timer a clock changed while running");
  AST_A_WR:
    assert property (tc_wr && !timer_a_run
      |=> timer_a_clock_sel == $past(reg_wdata[2:0])
      && timer_a_extra_prescale == $past(reg_wdata[3]))
    else $error("timer a clock write lost");
  AST_B_LOCK:
    assert property (timer_b_run
      |=> $stable(timer_b_clock_sel) && $stable(timer_b_extra_prescale))
    else $error("timer b clock changed while running");
  COV_MOD: cover property (mod_wr);
  COV_IRQ: cover property (irq);
  COV_RD: cover property (reg_rd && reg_addr == 8'h00);
endmodule

// >>> tb/test_compare_state_and_modify.sv
// Self-checking bench for the channel state and modify block
`timescale 1ns/1ns
module test_compare_state_and_modify;
  logic [0:0]  clk;
  logic        rst, reg_wr, reg_rd, timer_a_run, timer_b_run, irq, rd_d;
  logic        hall_in_0, hall_in_1, hall_in_2, hall_cmp_ready;
  logic        timer_a_extra_prescale, timer_b_extra_prescale;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, timer_a_count, timer_b_count, w;
  logic [15:0] cmp_val_0, cmp_val_1, cmp_val_2, cmp_val_3;
  logic [3:0]  cap_in, chan_state, cmp_out_active, ps, e4;
  logic [2:0]  timer_a_clock_sel, timer_b_clock_sel, hp;
  logic [31:0] ex;
  logic [31:0] exp_q[$];
  logic [15:0] mw[5] = '{16'h3847, 16'h0540, 16'h0000, 16'h4205, 16'h0300};
  logic [15:0] ms[5] = '{16'h0047, 16'h0042, 16'h0042, 16'h0005, 16'h0004};
  int          n_mismatch, n_tests, n_cyc;

  css_top i_dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .timer_a_count, .timer_b_count, .cmp_val_0, .cmp_val_1,
    .cmp_val_2, .cmp_val_3, .timer_a_run, .timer_b_run, .cap_in,
    .hall_in_0, .hall_in_1, .hall_in_2, .hall_cmp_ready,
    .timer_a_clock_sel, .timer_a_extra_prescale, .timer_b_clock_sel,
    .timer_b_extra_prescale, .chan_state, .cmp_out_active, .irq);

  // ----------------------------------------
  // Bus tasks and compare
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, m);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back({m, e});
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic complete_run;
    if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Read data watcher
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk) begin
    if (rd_d && exp_q.size() > 0) begin
      ex = exp_q.pop_front();
      chk(reg_rdata & ex[31:16], ex[15:0]);
    end
  end
  always @(posedge clk) begin
    n_cyc++;
    if (n_cyc == 4000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hA536));
    {reg_wr, reg_rd, reg_addr, reg_wdata, hall_cmp_ready, cap_in} = '0;
    {hall_in_0, hall_in_1, hall_in_2, timer_a_run, timer_b_run} = '0;
    {timer_a_count, timer_b_count} = '0;
    {cmp_val_0, cmp_val_1, cmp_val_2, cmp_val_3} = '1;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(8'h00, 16'h0000, 16'hFFFF);
    rd(8'h04, 16'h0000, 16'hFFFF);
    rd(8'h08, 16'h0000, 16'hFFFF);
    // Compare mode with random counts and passive selects
    for (int i = 0; i < 6; i++) begin
      ps = 4'($urandom);
      w = {1'b0, ps[3], 1'b0, ps[2], 1'b0, ps[1], 1'b0, ps[0], 8'h00};
      wr(8'h00, w);
      timer_a_count <= 16'($urandom);
      timer_b_count <= 16'($urandom);
      cmp_val_0 <= 16'($urandom);
      cmp_val_3 <= 16'($urandom);
      wt(1);
      cmp_val_1 <= timer_a_count;
      cmp_val_2 <= timer_a_count + 16'h0001;
      wt(2);
      e4 = {timer_b_count >= cmp_val_3, timer_a_count >= cmp_val_2,
        timer_a_count >= cmp_val_1, timer_a_count >= cmp_val_0};
      chk({12'h000, chan_state}, {12'h000, e4});
      chk({12'h000, cmp_out_active}, {12'h000, e4 ^ ps});
      rd(8'h00, w | {9'h000, e4[3], 3'h0, e4[2:0]}, 16'h5547);
    end
    // Software beats the compare result in the same cycle
    {cmp_val_0, cmp_val_1, cmp_val_2} <= 48'hFFFF_FFFF_FFFF;
    timer_a_count <= 16'h0000;
    {cmp_val_3, timer_b_count} <= {16'h0000, 16'hFFFF};
    wt(2);
    wr(8'h04, 16'h4001);
    wt(0);
    chk({12'h000, chan_state}, 16'h0001);
    wt(1);
    chk({12'h000, chan_state}, 16'h0008);
    // Capture mode, no edge: only software moves the bits
    wr(8'h0C, 16'hFF0F);
    wr(8'h04, 16'h4700);
    for (int i = 0; i < 5; i++) begin
      wr(8'h04, mw[i]);
      rd(8'h04, 16'h0000, 16'hFFFF);
      rd(8'h00, ms[i], 16'h0047);
    end
    // Rising capture edge on channel 0 and its interrupt
    wr(8'h0C, 16'hFFCF);
    wr(8'h10, 16'h001F);
    wr(8'h14, 16'h0001);
    rd(8'h10, 16'h0000, 16'hFFFF);
    cap_in <= 4'h1;
    wt(5);
    chk({12'h000, chan_state}, 16'h0005);
    cap_in <= 4'h0;
    wt(4);
    chk({12'h000, chan_state}, 16'h0005);
    chk({15'h0000, irq}, 16'h0001);
    wr(8'h14, 16'h0000);
    wt(0);
    chk({15'h0000, irq}, 16'h0000);
    wr(8'h14, 16'h0001);
    wt(0);
    chk({15'h0000, irq}, 16'h0001);
    wr(8'h10, 16'h0001);
    wt(0);
    chk({15'h0000, irq}, 16'h0000);
    wr(8'h04, 16'h0100);
    rd(8'h00, 16'h0004, 16'h0047);
    // Falling edge on channel 1, both edges on channel 2
    wr(8'h0C, 16'hFE7F);
    wr(8'h04, 16'h0400);
    cap_in <= 4'h6;
    wt(5);
    chk({12'h000, chan_state}, 16'h0004);
    cap_in <= 4'h0;
    wt(5);
    chk({12'h000, chan_state}, 16'h0006);
    wr(8'h04, 16'h0600);
    rd(8'h00, 16'h0000, 16'h0047);
    // Hall pattern latch
    for (int i = 0; i < 4; i++) begin
      hp = 3'($urandom);
      {hall_in_2, hall_in_1, hall_in_0} <= hp;
      wt(3);
      hall_cmp_ready <= 1'b1;
      wt(0);
      hall_cmp_ready <= 1'b0;
      {hall_in_2, hall_in_1, hall_in_0} <= ~hp;
      wt(4);
      rd(8'h00, {10'h000, hp, 3'h0}, 16'h0038);
      rd(8'h00, {10'h000, hp, 3'h0}, 16'h0038);
    end
    // Clock setup locked while running
    {timer_a_run, timer_b_run} <= 2'b11;
    wr(8'h08, 16'h0F0F);
    rd(8'h08, 16'h1010, 16'hFFFF);
    timer_a_run <= 1'b0;
    wr(8'h08, 16'h0F0D);
    rd(8'h08, 16'h100D, 16'hFFFF);
    timer_b_run <= 1'b0;
    wr(8'h08, 16'h0B00);
    wt(0);
    chk({8'h00, timer_b_extra_prescale, timer_b_clock_sel,
      timer_a_extra_prescale, timer_a_clock_sel}, 16'h00B0);
    wt(4);
    complete_run();
  end
endmodule

bind css_top css_chk i_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .timer_a_run(timer_a_run),
  .timer_b_run(timer_b_run), .timer_a_clock_sel(timer_a_clock_sel),
  .timer_a_extra_prescale(timer_a_extra_prescale),
  .timer_b_clock_sel(timer_b_clock_sel),
  .timer_b_extra_prescale(timer_b_extra_prescale),
  .chan_state(chan_state), .irq(irq));
